/* hdl/flsp_framer.sv */
// Frame level sequencing for an N_Port, classes 1 to 3
// How it works
// - Class 1 connect-requesting sequence starts with SOFc1.
// - Data waits for connect accept; stacked mode raises tx_ready_o for other connects but does not send them.
// - Inside an existing Class 1 connection new sequences start with SOFi1.
// - ACK copies first-seq, last-seq, last-data and initiative bits.
// - ACK inverts both context bits.
// - Frames after the first in a sequence use SOFn1, SOFn2 or SOFn3.
// - Class 1 last data flags last-data; last ACK ends EOFt or EOFdt.
// - Last-sequence with EOFt or EOFdt marks end of exchange.
// - Class 2 sequences start with SOFi2.
// - One R_RDY per received frame; Class 2 data also gets an ACK.
// - Class 2 last data frame flags last-data; initiative zero when retained.
// - Class 2 sequence ends only when all frames are accounted for.
// - Class 2 uses EOFt only on the final ACK after all frames arrive; the block also ends its last data frame with EOFt.
// - Class 3 sequences start with SOFi3 and expect no ACK.
// - Class 3 end of sequence is last-data together with EOFt.
// - Originator data: contexts 0, first-seq 1, last-seq 0 (the block sends tx_last_seq_i); ACKs carry contexts 1.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "flsp_params.svh"
module flsp_framer #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Transmit request: one data frame of a sequence
    input wire logic tx_req_i,
    input wire logic [1:0] tx_class_i,
    input wire logic tx_connect_i,
    input wire logic tx_last_data_i,
    input wire logic tx_last_seq_i,
    input wire logic tx_seq_init_i,
    input wire logic tx_new_dest_i,
    output logic tx_ready_o,
    // Transmit header toward the link
    output flsp_pkg::flsp_hdr_t tx_hdr_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    // Receive side from the link
    input wire logic rx_valid_i,
    input wire flsp_pkg::flsp_rx_t rx_frame_i,
    input wire logic conn_accept_i,
    input wire logic conn_removed_i,
    input wire logic rx_all_accounted_i,
    // Link responses and events
    output logic r_rdy_o,
    output logic seq_end_o,
    output logic xchg_end_o,
    output logic rx_seq_init_o
);
    import flsp_pkg::*;

    localparam int HDR_W = $bits(flsp_hdr_t);

    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT_CONN = 4'b0010,
        ST_IN_SEQ = 4'b0100,
        ST_EMIT = 4'b1000
    } flsp_state_t;

    initial begin
        if (CNT_W < 2 || CNT_W > 32) $error("flsp_framer: CNT_W out of range");
    end

    flsp_state_t state;
    flsp_hdr_t pend_hdr, ack_hdr, buf_in_data, buf_out_data, next_data_hdr, next_ack_hdr;
    logic connected, in_seq, stack_en, ack_pend, conn_sent;
    logic buf_in_ready, buf_in_valid, buf_out_valid, tx_take, rx_data, rx_last;
    logic [CNT_W-1:0] rx_count, rdy_count;

    // Build the ACK frame control from a received data frame
    function automatic logic [23:0] ack_fctl(input logic [23:0] fc);
        logic [23:0] r;
        r = 24'h00_0000;
        r[`FLSP_FC_FIRST_SEQ] = fc[`FLSP_FC_FIRST_SEQ];
        r[`FLSP_FC_LAST_SEQ] = fc[`FLSP_FC_LAST_SEQ];
        r[`FLSP_FC_LAST_DATA] = fc[`FLSP_FC_LAST_DATA];
        r[`FLSP_FC_SEQ_INIT] = fc[`FLSP_FC_SEQ_INIT];
        r[`FLSP_FC_XCHG_CTX] = ~fc[`FLSP_FC_XCHG_CTX];
        r[`FLSP_FC_SEQ_CTX] = ~fc[`FLSP_FC_SEQ_CTX];
        return r;
    endfunction : ack_fctl

    // Pick the start delimiter for a data frame
    function automatic flsp_sof_t pick_sof(input logic [1:0] cls, input logic first,
                                           input logic conn);
        flsp_sof_t s;
        s = FLSP_SOF_N3;
        case (cls)
            `FLSP_CLASS_1: begin
                if (!first) s = FLSP_SOF_N1;
                else if (conn) s = FLSP_SOF_I1;
                else s = FLSP_SOF_C1;
            end
            `FLSP_CLASS_2: s = first ? FLSP_SOF_I2 : FLSP_SOF_N2;
            default: s = first ? FLSP_SOF_I3 : FLSP_SOF_N3;
        endcase
        return s;
    endfunction : pick_sof

    // Data frame header from the request
    always_comb begin
        next_data_hdr = '0;
        next_data_hdr.sof = pick_sof(tx_class_i, !in_seq, connected && !tx_connect_i);
        next_data_hdr.eof = tx_last_data_i ? FLSP_EOF_T : FLSP_EOF_N;
        next_data_hdr.is_ack = 1'b0;
        next_data_hdr.fctl[`FLSP_FC_XCHG_CTX] = 1'b0;
        next_data_hdr.fctl[`FLSP_FC_SEQ_CTX] = 1'b0;
        next_data_hdr.fctl[`FLSP_FC_FIRST_SEQ] = 1'b1;
        next_data_hdr.fctl[`FLSP_FC_LAST_SEQ] = tx_last_seq_i;
        next_data_hdr.fctl[`FLSP_FC_LAST_DATA] = tx_last_data_i;
        // Initiative only meaningful on the last frame; zero keeps it
        next_data_hdr.fctl[`FLSP_FC_SEQ_INIT] = tx_last_data_i && tx_seq_init_i;
    end

    // Receive decode
    assign rx_data = rx_valid_i && !rx_frame_i.is_ack;
    assign rx_last = rx_frame_i.fctl[`FLSP_FC_LAST_DATA];

    // ACK header for a received class 1 or 2 data frame
    always_comb begin
        next_ack_hdr = '0;
        next_ack_hdr.is_ack = 1'b1;
        next_ack_hdr.fctl = ack_fctl(rx_frame_i.fctl);
        next_ack_hdr.sof = (rx_frame_i.cls == `FLSP_CLASS_1) ? FLSP_SOF_N1 : FLSP_SOF_N2;
        if (rx_last) begin
            if (rx_frame_i.cls == `FLSP_CLASS_1) begin
                next_ack_hdr.eof = rx_frame_i.fctl[`FLSP_FC_LAST_SEQ] ?
                                   FLSP_EOF_DT : FLSP_EOF_T;
            end else if (rx_all_accounted_i) begin
                next_ack_hdr.eof = FLSP_EOF_T;
            end
        end
    end

    // Taken only while ready
    assign tx_take = tx_req_i && tx_ready_o;

    // Sequencer for outgoing data frames
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            pend_hdr <= '0;
            in_seq <= 1'b0;
            tx_ready_o <= 1'b0;
        end else begin
            case (state)
                ST_IDLE, ST_IN_SEQ: begin
                    tx_ready_o <= 1'b1;
                    if (tx_take) begin
                        tx_ready_o <= 1'b0;
                        pend_hdr <= next_data_hdr;
                        in_seq <= !tx_last_data_i;
                        state <= ST_EMIT;
                        if (next_data_hdr.sof == FLSP_SOF_C1) begin
                            state <= ST_WAIT_CONN;
                        end
                    end
                end
                ST_WAIT_CONN: begin
                    // Hold data until the connect is accepted
                    tx_ready_o <= 1'b0;
                    if (stack_en && tx_req_i && tx_connect_i && tx_new_dest_i) begin
                        tx_ready_o <= 1'b1;
                    end
                    if (conn_accept_i) begin
                        state <= in_seq ? ST_IN_SEQ : ST_IDLE;
                        tx_ready_o <= 1'b1;
                    end
                end
                ST_EMIT: begin
                    if (!ack_pend && buf_in_ready) begin
                        state <= in_seq ? ST_IN_SEQ : ST_IDLE;
                        tx_ready_o <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    tx_ready_o <= 1'b0;
                end
            endcase
        end
    end

    // Connection state follows accept and removal
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            connected <= 1'b0;
        end else if (conn_removed_i) begin
            connected <= 1'b0;
        end else if (conn_accept_i) begin
            connected <= 1'b1;
        end
    end

    // Connect frame is emitted once in the wait state, behind any pending ACK
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            conn_sent <= 1'b0;
        end else if (state != ST_WAIT_CONN) begin
            conn_sent <= 1'b0;
        end else if (!ack_pend && buf_in_ready) begin
            conn_sent <= 1'b1;
        end
    end

    // Pending ACK for class 1 and 2 data frames; class 3 gets none
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_pend <= 1'b0;
            ack_hdr <= '0;
        end else begin
            if (ack_pend && buf_in_ready) ack_pend <= 1'b0;
            if (rx_data && rx_frame_i.cls != `FLSP_CLASS_3) begin
                ack_pend <= 1'b1;
                ack_hdr <= next_ack_hdr;
            end
        end
    end

    // ACKs go first; a data frame waits a cycle behind them
    always_comb begin
        buf_in_valid = 1'b0;
        buf_in_data = pend_hdr;
        if (ack_pend) begin
            buf_in_valid = 1'b1;
            buf_in_data = ack_hdr;
        end else if (state == ST_EMIT || (state == ST_WAIT_CONN && !conn_sent)) begin
            buf_in_valid = 1'b1;
        end
    end

    // Two-entry buffer so a stalled link loses no header
    flsp_skid #(
        .WIDTH(HDR_W)
    ) u_buf (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .in_data_i(buf_in_data),
        .in_valid_i(buf_in_valid),
        .in_ready_o(buf_in_ready),
        .out_data_o(buf_out_data),
        .out_valid_o(buf_out_valid),
        .out_ready_i(tx_ready_i)
    );

    // Output register stage toward the link
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_valid_o <= 1'b0;
            tx_hdr_o <= '0;
        end else if (tx_ready_i) begin
            tx_valid_o <= buf_out_valid;
            tx_hdr_o <= buf_out_data;
        end
    end

    // One R_RDY per received frame of any kind, SOFc1 included
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_rdy_o <= 1'b0;
        end else begin
            r_rdy_o <= rx_valid_i;
        end
    end

    // Sequence and exchange end detection on received frames
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            seq_end_o <= 1'b0;
            xchg_end_o <= 1'b0;
            rx_seq_init_o <= 1'b0;
        end else begin
            seq_end_o <= 1'b0;
            xchg_end_o <= 1'b0;
            if (rx_valid_i) begin
                case (rx_frame_i.cls)
                    `FLSP_CLASS_3: begin
                        seq_end_o <= rx_data && rx_last &&
                                     rx_frame_i.eof == FLSP_EOF_T;
                    end
                    `FLSP_CLASS_2: begin
                        seq_end_o <= rx_data && rx_last && rx_all_accounted_i;
                    end
                    default: begin
                        seq_end_o <= rx_frame_i.is_ack && rx_frame_i.eof != FLSP_EOF_N;
                    end
                endcase
                xchg_end_o <= rx_frame_i.fctl[`FLSP_FC_LAST_SEQ] &&
                              rx_frame_i.eof != FLSP_EOF_N;
                if (rx_data && rx_last) begin
                    rx_seq_init_o <= rx_frame_i.fctl[`FLSP_FC_SEQ_INIT];
                end
            end
        end
    end

    // Control register: stacked connect enable
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stack_en <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == `FLSP_REG_CTRL) begin
            stack_en <= reg_wdata_i[`FLSP_CTRL_STACK];
        end
    end

    // Frame counters
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_count <= '0;
            rdy_count <= '0;
        end else begin
            if (rx_data) rx_count <= rx_count + 1'b1;
            if (r_rdy_o) rdy_count <= rdy_count + 1'b1;
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            reg_rdata_o <= 32'h0000_0000;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `FLSP_REG_CTRL: reg_rdata_o <= {31'h0000_0000, stack_en};
                    `FLSP_REG_STAT: reg_rdata_o <= {26'h000_0000, connected, in_seq,
                                                    state};
                    `FLSP_REG_RXCNT: reg_rdata_o <= 32'(rx_count);
                    `FLSP_REG_RDYCNT: reg_rdata_o <= 32'(rdy_count);
                    default: reg_rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : flsp_framer

/* hdl/flsp_skid.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module flsp_skid #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // Drain side
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    logic [WIDTH-1:0] mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    initial begin
        if (WIDTH < 1) $error("flsp_skid: WIDTH must be positive");
    end

    // Handshakes on both sides
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign in_ready_o = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o = mem[rd_ptr];

    // Storage array, no reset needed on data
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers and fill count
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : flsp_skid

/* pkg/flsp_params.svh */
// Constants for the frame level sequencing block
`ifndef FLSP_PARAMS_SVH
`define FLSP_PARAMS_SVH
// Frame control bit positions
`define FLSP_FC_XCHG_CTX 23
`define FLSP_FC_SEQ_CTX 22
`define FLSP_FC_FIRST_SEQ 21
`define FLSP_FC_LAST_SEQ 20
`define FLSP_FC_LAST_DATA 19
`define FLSP_FC_SEQ_INIT 16
// Class codes
`define FLSP_CLASS_1 2'h1
`define FLSP_CLASS_2 2'h2
`define FLSP_CLASS_3 2'h3
// Register indices
`define FLSP_REG_CTRL 4'h0
`define FLSP_REG_STAT 4'h1
`define FLSP_REG_RXCNT 4'h2
`define FLSP_REG_RDYCNT 4'h3
// Control register fields
`define FLSP_CTRL_STACK 0
`endif

/* pkg/flsp_pkg.sv */
// Types of the frame level sequencing block
package flsp_pkg;
    // Start of frame delimiters
    typedef enum logic [2:0] {
        FLSP_SOF_C1 = 3'h0,
        FLSP_SOF_I1 = 3'h1,
        FLSP_SOF_N1 = 3'h2,
        FLSP_SOF_I2 = 3'h3,
        FLSP_SOF_N2 = 3'h4,
        FLSP_SOF_I3 = 3'h5,
        FLSP_SOF_N3 = 3'h6
    } flsp_sof_t;
    // End of frame delimiters
    typedef enum logic [1:0] {
        FLSP_EOF_N = 2'h0,
        FLSP_EOF_T = 2'h1,
        FLSP_EOF_DT = 2'h2
    } flsp_eof_t;
    // Transmit frame header summary
    typedef struct packed {
        flsp_sof_t sof;
        flsp_eof_t eof;
        logic is_ack;
        logic [23:0] fctl;
    } flsp_hdr_t;
    // Received frame summary
    typedef struct packed {
        logic [1:0] cls;
        flsp_sof_t sof;
        flsp_eof_t eof;
        logic is_ack;
        logic [23:0] fctl;
    } flsp_rx_t;
endpackage : flsp_pkg

/* tb/flsp_framer_chk.sv */
// Port checker for the frame sequencing block
`timescale 1ns/1ps
module flsp_framer_chk (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire flsp_pkg::flsp_hdr_t tx_hdr_o,
    input wire logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic rx_valid_i,
    input wire flsp_pkg::flsp_rx_t rx_frame_i,
    input wire logic conn_accept_i,
    input wire logic r_rdy_o,
    input wire logic seq_end_o,
    input wire logic xchg_end_o
);
    import flsp_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic in_seq, c1_wait, dat_go;
    assign dat_go = tx_valid_o && tx_ready_i && !tx_hdr_o.is_ack;
    // Moves only on an accepted frame
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_seq <= 1'b0;
        end else if (dat_go) begin
            in_seq <= !tx_hdr_o.fctl[19];
        end
    end
    // Connect wait opens on an accepted connect frame
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            c1_wait <= 1'b0;
        end else if (conn_accept_i) begin
            c1_wait <= 1'b0;
        end else if (dat_go && tx_hdr_o.sof == FLSP_SOF_C1) begin
            c1_wait <= 1'b1;
        end
    end
    // Received frames that end a sequence or an exchange
    sequence s_c3_end;
        rx_valid_i && rx_frame_i.cls == 2'h3 && !rx_frame_i.is_ack
            && rx_frame_i.fctl[19] && rx_frame_i.eof == FLSP_EOF_T;
    endsequence
    sequence s_xchg_end;
        rx_valid_i && rx_frame_i.fctl[20]
            && (rx_frame_i.eof == FLSP_EOF_T || rx_frame_i.eof == FLSP_EOF_DT);
    endsequence
    rdy_per_rx_a: assert property (rx_valid_i |=> r_rdy_o)
        else $error("no R_RDY after a frame");
    rdy_cause_a: assert property (r_rdy_o |-> $past(rx_valid_i))
        else $error("R_RDY without a frame");
    c3_end_a: assert property (s_c3_end |=> seq_end_o)
        else $error("class 3 end missed");
    xchg_end_a: assert property (s_xchg_end |=> xchg_end_o)
        else $error("exchange end missed");
    ack_ctx_a: assert property (tx_valid_o && tx_hdr_o.is_ack
        |-> tx_hdr_o.fctl[23:22] == 2'h3)
        else $error("ACK contexts wrong");
    dat_ctx_a: assert property (tx_valid_o && !tx_hdr_o.is_ack
        |-> tx_hdr_o.fctl[23:21] == 3'h1)
        else $error("data contexts wrong");
    cont_sof_a: assert property (tx_valid_o && !tx_hdr_o.is_ack && in_seq
        |-> tx_hdr_o.sof inside {FLSP_SOF_N1, FLSP_SOF_N2, FLSP_SOF_N3})
        else $error("continuing delimiter wrong");
    init_sof_a: assert property (tx_valid_o && !tx_hdr_o.is_ack && !in_seq
        |-> tx_hdr_o.sof inside {FLSP_SOF_C1, FLSP_SOF_I1, FLSP_SOF_I2, FLSP_SOF_I3})
        else $error("initiating delimiter wrong");
    conn_hold_a: assert property (c1_wait && tx_valid_o |-> tx_hdr_o.is_ack)
        else $error("data sent before accept");
    stall_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_hdr_o))
        else $error("header moved in a stall");
    rd_zero_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside its cycle");
endmodule : flsp_framer_chk
bind flsp_framer flsp_framer_chk u_flsp_framer_chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .tx_hdr_o(tx_hdr_o), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .rx_valid_i(rx_valid_i), .rx_frame_i(rx_frame_i),
    .conn_accept_i(conn_accept_i), .r_rdy_o(r_rdy_o), .seq_end_o(seq_end_o),
    .xchg_end_o(xchg_end_o)
);

/* tb/flsp_framer_tb_top.sv */
// Self-checking bench of the frame sequencing block
`timescale 1ns/1ps
`include "flsp_params.svh"
module flsp_framer_tb_top;
    import flsp_pkg::*;
    typedef struct packed {
        flsp_hdr_t h;
        logic [29:0] m;
    } flsp_exp_t;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, tx_req_i = 1'b0, tx_connect_i = 1'b0;
    logic [1:0] tx_class_i = 2'h1;
    logic tx_last_data_i = 1'b0, tx_last_seq_i = 1'b0, tx_seq_init_i = 1'b0;
    logic rx_all_accounted_i = 1'b0, connected = 1'b0, in_seq = 1'b0, rd_pend = 1'b0;
    logic [31:0] reg_rdata_o;
    flsp_hdr_t tx_hdr_o;
    flsp_rx_t rx_frame_i;
    logic tx_ready_o, tx_valid_o, tx_ready_i, rx_valid_i, conn_accept_i;
    logic r_rdy_o, seq_end_o, xchg_end_o, rx_seq_init_o;
    int err_total = 0, checked = 0, cyc = 0, n_dat = 0, n_all = 0;
    logic [31:0] rd_q[$];
    flsp_exp_t dat_q[$], ack_q[$];
    flsp_exp_t e;
    always #4 core_clk_i = ~core_clk_i;
    flsp_framer u_flsp_framer (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .tx_req_i(tx_req_i), .tx_class_i(tx_class_i),
        .tx_connect_i(tx_connect_i), .tx_last_data_i(tx_last_data_i),
        .tx_last_seq_i(tx_last_seq_i), .tx_seq_init_i(tx_seq_init_i),
        .tx_new_dest_i(1'b0), .tx_ready_o(tx_ready_o), .tx_hdr_o(tx_hdr_o),
        .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .rx_valid_i(rx_valid_i),
        .rx_frame_i(rx_frame_i), .conn_accept_i(conn_accept_i), .conn_removed_i(1'b0),
        .rx_all_accounted_i(rx_all_accounted_i), .r_rdy_o(r_rdy_o),
        .seq_end_o(seq_end_o), .xchg_end_o(xchg_end_o), .rx_seq_init_o(rx_seq_init_o)
    );
    flsp_link_model u_flsp_link_model (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .hdr_i(tx_hdr_o), .valid_i(tx_valid_o),
        .ready_o(tx_ready_i), .conn_accept_o(conn_accept_i), .rx_valid_o(rx_valid_i),
        .rx_frame_o(rx_frame_i)
    );
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results();
        $display("Checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    // Outputs matched against the oldest note
    always @(posedge core_clk_i) begin
        rd_pend <= reg_rd_i;
        if (rd_pend) chk(reg_rdata_o, rd_q.pop_front());
        if (tx_valid_o && tx_ready_i) begin
            e = tx_hdr_o.is_ack ? ack_q.pop_front() : dat_q.pop_front();
            chk({2'h0, tx_hdr_o & e.m}, {2'h0, e.h & e.m});
        end
    end
    // Hang guard
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] x);
        rd_q.push_back(x);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
    endtask : rd
    // One data frame; initiative is random where it carries no meaning
    task automatic tx(input logic [1:0] c, input logic cn, ld, ls, si);
        flsp_exp_t x;
        if (!ld) si = 1'($urandom);
        if (in_seq) x.h.sof = flsp_sof_t'(3'(2 * c));
        else if (c == 2'h1) x.h.sof = (cn || !connected) ? FLSP_SOF_C1 : FLSP_SOF_I1;
        else x.h.sof = flsp_sof_t'(3'(2 * c - 1));
        x.h.eof = ld ? FLSP_EOF_T : FLSP_EOF_N;
        x.h.is_ack = 1'b0;
        x.h.fctl = {3'h1, ls, ld, 2'h0, si, 16'h0};
        x.m = {11'h7FF, 2'h0, ld, 16'h0};
        dat_q.push_back(x);
        in_seq = !ld;
        @(negedge core_clk_i);
        while (!tx_ready_o) @(negedge core_clk_i);
        @(posedge core_clk_i);
        tx_req_i <= 1'b1;
        tx_class_i <= c;
        tx_connect_i <= cn;
        tx_last_data_i <= ld;
        tx_last_seq_i <= ls;
        tx_seq_init_i <= si;
        @(posedge core_clk_i);
        tx_req_i <= 1'b0;
        if (cn) begin
            repeat (6) begin
                @(negedge core_clk_i);
                chk(tx_ready_o, 32'h0);
            end
            connected = 1'b1;
        end
    endtask : tx
    // One received frame; sx 2 leaves the end flag unchecked
    task automatic rx(input logic [1:0] c, input logic ak, ld, input flsp_eof_t ef,
                      input logic [1:0] sx);
        flsp_rx_t f;
        flsp_exp_t x;
        logic [23:0] r;
        r = 24'($urandom);
        f.cls = c;
        f.sof = (ak || ld) ? flsp_sof_t'(3'(2 * c)) : (c == 2'h1) ? FLSP_SOF_C1 :
                flsp_sof_t'(3'(2 * c - 1));
        f.eof = ef;
        f.is_ack = ak;
        f.fctl = {ak ? 2'h3 : 2'h0, r[21:20], ld, r[18:0]};
        x.h = {FLSP_SOF_C1, FLSP_EOF_N, 1'b1, f.fctl ^ 24'hC00000};
        x.m = {5'h03, 1'b1, 24'hF90000};
        n_all++;
        if (!ak) n_dat++;
        u_flsp_link_model.send(f);
        if (c == 2'h1 && ld) x.h.eof = f.fctl[20] ? FLSP_EOF_DT : FLSP_EOF_T;
        if (c == 2'h2 && ld && rx_all_accounted_i) x.h.eof = FLSP_EOF_T;
        if (!ak && c != 2'h3) ack_q.push_back(x);
        @(negedge core_clk_i);
        if (sx != 2'h2) chk(seq_end_o, {31'h0, sx[0]});
        chk(xchg_end_o, {31'h0, f.fctl[20] && ef != FLSP_EOF_N});
        if (!ak && ld) chk(rx_seq_init_o, {31'h0, f.fctl[16]});
    endtask : rx
    initial begin
        void'($urandom(32'hDD38F7F2));
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        wr(`FLSP_REG_CTRL, 32'h1);
        rd(`FLSP_REG_CTRL, 32'h1);
        wr(4'hF, 32'hFFFF_FFFF);
        rd(4'hF, 32'h0);
        wr(`FLSP_REG_CTRL, 32'h0);
        rd(`FLSP_REG_CTRL, 32'h0);
        tx(2'h1, 1'b1, 1'b0, 1'b0, 1'b0);
        tx(2'h1, 1'b0, 1'b0, 1'b0, 1'b0);
        tx(2'h1, 1'b0, 1'b1, 1'b0, 1'b0);
        tx(2'h1, 1'b0, 1'b1, 1'b0, 1'b0);
        for (int c = 2; c <= 3; c++) begin
            tx(2'(c), 1'b0, 1'b0, 1'b0, 1'b1);
            tx(2'(c), 1'b0, 1'b1, c == 3, 1'b0);
        end
        rx(2'h1, 1'b0, 1'b0, FLSP_EOF_N, 2'h2);
        rx(2'h1, 1'b0, 1'b1, FLSP_EOF_T, 2'h2);
        rx(2'h1, 1'b1, 1'b1, FLSP_EOF_T, 2'h1);
        rx_all_accounted_i <= 1'b1;
        rx(2'h2, 1'b0, 1'b1, FLSP_EOF_T, 2'h1);
        rx_all_accounted_i <= 1'b0;
        rx(2'h2, 1'b0, 1'b1, FLSP_EOF_T, 2'h0);
        rx(2'h2, 1'b1, 1'b0, FLSP_EOF_N, 2'h2);
        rx(2'h3, 1'b0, 1'b0, FLSP_EOF_N, 2'h0);
        rx(2'h3, 1'b0, 1'b1, FLSP_EOF_T, 2'h1);
        repeat (60) @(posedge core_clk_i);
        chk(dat_q.size() + ack_q.size(), 32'h0);
        rd(`FLSP_REG_RXCNT, n_dat);
        rd(`FLSP_REG_RDYCNT, n_all);
        repeat (3) @(posedge core_clk_i);
        results();
    end
endmodule : flsp_framer_tb_top

/* tb/flsp_link_model.sv */
// Far side model: header sink, connect answer, frame source
`timescale 1ns/1ps
module flsp_link_model #(
    parameter int ACC_DLY = 8
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Headers from the block
    input wire flsp_pkg::flsp_hdr_t hdr_i,
    input wire logic valid_i,
    output logic ready_o,
    // Toward the block
    output logic conn_accept_o,
    output logic rx_valid_o,
    output flsp_pkg::flsp_rx_t rx_frame_o
);
    import flsp_pkg::*;
    int acc_cnt;
    initial begin
        rx_valid_o = 1'b0;
        rx_frame_o = '0;
    end
    // Random stalls keep the block's buffer under pressure
    always @(posedge core_clk_i) begin
        ready_o <= ($urandom % 4) != 0;
    end
    // Destination accepts a connect request some cycles after it lands
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_cnt <= 0;
            conn_accept_o <= 1'b0;
        end else begin
            conn_accept_o <= (acc_cnt == 1);
            if (valid_i && ready_o && !hdr_i.is_ack && hdr_i.sof == FLSP_SOF_C1) begin
                acc_cnt <= ACC_DLY;
            end else if (acc_cnt != 0) begin
                acc_cnt <= acc_cnt - 1;
            end
        end
    end
    // One received frame, then inverse lines
    task automatic send(input flsp_rx_t f);
        @(posedge core_clk_i);
        rx_valid_o <= 1'b1;
        rx_frame_o <= f;
        @(posedge core_clk_i);
        rx_valid_o <= 1'b0;
        rx_frame_o <= ~f;
    endtask : send
endmodule : flsp_link_model
